// [rtl/gps_capture_pkg.sv]
// constants and types shared by the gps sample capture block
package gps_capture_pkg;

  // register byte offsets on the apb bus
  localparam logic [11:0] CFG_OFS = 12'h024;
  localparam logic [11:0] HANDOVER_OFS = 12'h028;
  localparam logic [11:0] TALLY_OFS = 12'h02C;
  localparam logic [11:0] STATUS_OFS = 12'h030;

  // capture_config field positions
  localparam int CFG_WIDTH = 6;
  localparam int CFG_ENABLE_BIT = 0;
  localparam int CFG_FORMAT_LSB = 1;
  localparam int CFG_MAG_BIT = 3;
  localparam int CFG_INVERT_BIT = 4;
  localparam int CFG_TRACK_BIT = 5;

  // status field positions
  localparam int STATUS_OVERFLOW_BIT = 0;
  localparam int STATUS_COUNTING_BIT = 1;

  // reset values
  localparam logic [5:0] CFG_RESET = 6'h00;
  localparam logic [31:0] HANDOVER_RESET = 32'h00000000;
  localparam logic [31:0] TALLY_RESET = 32'h00000000;

  // link pins: {mag[2:0], sign, clk}
  localparam int LINK_WIDTH = 5;
  localparam logic [5:0] WORD_BITS = 6'h20;

  // packing formats held in the fifo
  typedef enum logic [1:0] {
    FMT_UNPACKED = 2'h0,
    FMT_PACKED = 2'h1,
    FMT_SUPER = 2'h2,
    FMT_RESERVED = 2'h3
  } format_t;

endpackage

// [rtl/gps_sample_capture.sv]
// gps serial sample capture with apb registers and two-entry output buffer
`timescale 1ns/1ps
module gps_sample_capture
  import gps_capture_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic gpsClk,
  input wire logic gpsSign,
  input wire logic [2:0] gpsMag,
  output logic [31:0] rxData,
  output logic rxValid,
  input wire logic rxReady,
  output logic spiRxDeny
);

  typedef struct packed {
    logic [CFG_WIDTH-1:0] cfg;
    logic [31:0] handover;
    logic [31:0] tally;
    logic [31:0] down;
    logic counting;
    logic overflow;
    logic deny;
    logic [LINK_WIDTH-1:0] s1;
    logic [LINK_WIDTH-1:0] s2;
    logic [LINK_WIDTH-1:0] s3;
    logic [LINK_WIDTH-1:0] lvl;
    logic [31:0] word;
    logic [5:0] pos;
    logic [1:0][31:0] bufw;
    logic [1:0] vld;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } state_t;

  state_t state_q;
  state_t state_d;
  logic push;
  logic sampleEdge;
  logic wrAcc;

  // bits per sample: sign plus one or three magnitude bits
  function automatic logic [5:0] sampleWidth(input logic mag3);
    sampleWidth = mag3 ? 6'h04 : 6'h02;
  endfunction

  // slot each sample takes inside a fifo word
  function automatic logic [5:0] slotWidth(input logic [1:0] fmt,
                                           input logic mag3);
    unique case (format_t'(fmt))
      FMT_PACKED: slotWidth = 6'h04;
      FMT_SUPER: slotWidth = sampleWidth(mag3);
      default: slotWidth = WORD_BITS; // unpacked, reserved acts as unpacked
    endcase
  endfunction

  // read mux shared by the access decode
  function automatic logic [31:0] readMux(input logic [11:0] addr,
                                          input state_t s);
    unique case (addr)
      CFG_OFS: readMux = {26'h0000000, s.cfg};
      HANDOVER_OFS: readMux = s.handover;
      TALLY_OFS: readMux = s.tally;
      STATUS_OFS: readMux = {30'h00000000, s.counting, s.overflow};
      default: readMux = 32'h00000000;
    endcase
  endfunction

  function automatic logic isMapped(input logic [11:0] addr);
    isMapped = (addr == CFG_OFS) || (addr == HANDOVER_OFS) ||
      (addr == TALLY_OFS) || (addr == STATUS_OFS);
  endfunction

  // all next-state logic of the block
  always_comb begin
    logic [LINK_WIDTH-1:0] linkIn;
    logic inv;
    logic [3:0] sample;
    logic [5:0] slot;
    logic [6:0] nextPos;
    logic trackFell;
    logic capOn;
    logic [1:0] vldAfter;
    linkIn = {gpsMag, gpsSign, gpsClk};
    inv = 1'b0;
    sample = 4'h0;
    slot = 6'h00;
    nextPos = 7'h00;
    trackFell = 1'b0;
    capOn = 1'b0;
    vldAfter = 2'h0;
    state_d = state_q;
    push = 1'b0;
    wrAcc = 1'b0;

    // three-stage synchronisers; a level counts once stages two and three agree
    state_d.s1 = linkIn;
    state_d.s2 = state_q.s1;
    state_d.s3 = state_q.s2;
    for (int i = 0; i < LINK_WIDTH; i++) begin
      if (state_q.s2[i] == state_q.s3[i]) begin
        state_d.lvl[i] = state_q.s3[i];
      end
    end
    // polarity applied before edge detection
    inv = state_q.cfg[CFG_INVERT_BIT];
    sampleEdge = (state_d.lvl[0] ^ inv) & ~(state_q.lvl[0] ^ inv);
    if (state_q.cfg[CFG_MAG_BIT]) begin
      sample = {state_d.lvl[1], state_d.lvl[4:2]};
    end else begin
      sample = {2'b00, state_d.lvl[1], state_d.lvl[2]};
    end

    // apb: one wait state, the transfer completes on the second access cycle
    if (psel && penable && !state_q.pready) begin
      state_d.pready = 1'b1;
      state_d.prdata = readMux(paddr, state_q);
      state_d.pslverr = !isMapped(paddr);
    end else begin
      state_d.pready = 1'b0;
      state_d.pslverr = 1'b0;
      if (psel && penable && pwrite && !state_q.pslverr) begin
        wrAcc = 1'b1;
        unique case (paddr)
          CFG_OFS: state_d.cfg = pwdata[CFG_WIDTH-1:0];
          HANDOVER_OFS: begin
            state_d.handover = pwdata;
            state_d.down = pwdata;
          end
          STATUS_OFS: begin
            if (pwdata[STATUS_OVERFLOW_BIT]) begin
              state_d.overflow = 1'b0;
            end
          end
          default: ; // tally is read-only, writes ignored
        endcase
      end
    end

    // leaving tracking or capture reloads the countdown
    trackFell = state_q.cfg[CFG_TRACK_BIT] & ~state_d.cfg[CFG_TRACK_BIT];
    if (trackFell || !state_d.cfg[CFG_ENABLE_BIT]) begin
      state_d.down = state_d.handover;
      state_d.counting = 1'b0;
    end
    if (!state_d.cfg[CFG_ENABLE_BIT]) begin
      state_d.word = 32'h00000000;
      state_d.pos = 6'h00;
    end
    state_d.deny = state_d.cfg[CFG_ENABLE_BIT];

    // switch-over once tracking is requested and the countdown is spent
    if (state_d.cfg[CFG_TRACK_BIT] && state_d.cfg[CFG_ENABLE_BIT] &&
        !state_q.counting && state_d.down == 32'h00000000) begin
      state_d.counting = 1'b1;
      state_d.tally = TALLY_RESET;
      state_d.word = 32'h00000000;
      state_d.pos = 6'h00;
    end

    // a change of enable in this cycle takes no sample, avoiding half words
    capOn = state_q.cfg[CFG_ENABLE_BIT] & state_d.cfg[CFG_ENABLE_BIT];
    if (capOn && sampleEdge) begin
      if (state_q.counting && state_d.counting) begin
        state_d.tally = state_q.tally + 32'h00000001;
      end else if (!state_q.counting && !state_d.counting) begin
        if (state_d.down != 32'h00000000) begin
          state_d.down = state_d.down - 32'h00000001;
        end
        slot = slotWidth(state_q.cfg[CFG_FORMAT_LSB +: 2],
                         state_q.cfg[CFG_MAG_BIT]);
        state_d.word = state_q.word | ({28'h0000000, sample} << state_q.pos);
        nextPos = {1'b0, state_q.pos} + {1'b0, slot};
        if (nextPos >= {1'b0, WORD_BITS}) begin
          push = 1'b1;
          state_d.pos = 6'h00;
        end else begin
          state_d.pos = nextPos[5:0];
        end
      end
    end

    // two-entry buffer: pop first so a full buffer drained now still accepts
    vldAfter = state_q.vld;
    if (state_q.vld[0] && rxReady) begin
      state_d.bufw[0] = state_q.bufw[1];
      vldAfter = {1'b0, state_q.vld[1]};
    end
    if (push) begin
      state_d.word = 32'h00000000;
      if (!vldAfter[0]) begin
        state_d.bufw[0] = state_d.word | state_q.word |
          ({28'h0000000, sample} << state_q.pos);
        vldAfter[0] = 1'b1;
      end else if (!vldAfter[1]) begin
        state_d.bufw[1] = state_q.word |
          ({28'h0000000, sample} << state_q.pos);
        vldAfter[1] = 1'b1;
      end else begin
        // the link cannot be stalled, so a lost word is flagged; set wins
        state_d.overflow = 1'b1;
      end
    end
    state_d.vld = vldAfter;
  end

  // single register stage; clock enable freezes everything except the synchronous reset
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_q <= '0;
      state_q.cfg <= CFG_RESET;
      state_q.handover <= HANDOVER_RESET;
      state_q.tally <= TALLY_RESET;
      state_q.down <= HANDOVER_RESET;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  assign prdata = state_q.prdata;
  assign pready = state_q.pready;
  assign pslverr = state_q.pslverr;
  assign rxData = state_q.bufw[0];
  assign rxValid = state_q.vld[0];
  assign spiRxDeny = state_q.deny;

  // checks on the capture behaviour
  sequence seqIdle;
    !state_q.cfg[CFG_TRACK_BIT] ##1 !state_q.cfg[CFG_TRACK_BIT];
  endsequence

  sequence seqLeave;
    state_q.counting ##1 !state_q.cfg[CFG_TRACK_BIT];
  endsequence

  sequence seqReadTally;
    ce && psel && penable && !pwrite && paddr == TALLY_OFS && !pready;
  endsequence

  AST_DENY: assert property (@(posedge mclk) disable iff (!rstn)
    spiRxDeny == state_q.cfg[CFG_ENABLE_BIT])
    else $error("rx fifo deny does not follow capture enable");

  AST_OFF_NO_PUSH: assert property (@(posedge mclk) disable iff (!rstn)
    !state_q.cfg[CFG_ENABLE_BIT] |-> !push)
    else $error("word pushed while capture is off");

  AST_COUNT_NO_PUSH: assert property (@(posedge mclk)
    disable iff (!rstn) state_q.counting |-> !push)
    else $error("word stored while counting samples");

  AST_COUNT_TRACK: assert property (@(posedge mclk) disable iff (!rstn)
    state_q.counting |-> state_q.cfg[CFG_TRACK_BIT])
    else $error("counting without tracking selected");

  AST_TALLY_CLEAR: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(state_q.counting) |-> state_q.tally == 32'h00000000)
    else $error("tally not cleared on switch-over");

  AST_TALLY_HOLD: assert property (@(posedge mclk) disable iff (!rstn)
    seqIdle |-> $stable(state_q.tally))
    else $error("tally changed outside tracking");

  AST_DOWN_STEP: assert property (@(posedge mclk) disable iff (!rstn)
    ce && sampleEdge && !wrAcc && state_q.cfg[CFG_ENABLE_BIT] &&
    !state_q.counting && !state_q.cfg[CFG_TRACK_BIT] &&
    state_q.down != 32'h00000000
    |=> state_q.down == $past(state_q.down) - 32'h00000001)
    else $error("countdown did not drop by one");

  AST_RELOAD: assert property (@(posedge mclk) disable iff (!rstn)
    seqLeave |-> state_q.down == state_q.handover && !state_q.counting)
    else $error("countdown not reloaded on leaving tracking");

  AST_READ_TALLY: assert property (@(posedge mclk) disable iff (!rstn)
    seqReadTally |=> pready && prdata == $past(state_q.tally))
    else $error("tally read returned a wrong value");

endmodule

// [testbench/gps_source.sv]
// behavioural gps front-end model driving one sample per link clock pulse
`timescale 1ns/1ps
module gps_source (
  output logic gpsClk,
  output logic gpsSign,
  output logic [2:0] gpsMag
);
  // link clock idles low and runs only while a sample is sent
  initial begin
    gpsClk = 1'h0;
    gpsSign = 1'h0;
    gpsMag = 3'h0;
  end

  // a is held around the rising pin edge, b around the falling one
  task automatic send(input logic [3:0] a, input logic [3:0] b);
    #7;
    {gpsSign, gpsMag} = a;
    #100;
    gpsClk = 1'h1;
    #100;
    {gpsSign, gpsMag} = b;
    #100;
    gpsClk = 1'h0;
    #93;
    // hold time over: show the inverse so a late sample cannot pass
    // the 7 ns lead-in plus this shorter tail keeps the period at 400 ns
    {gpsSign, gpsMag} = ~b;
  endtask
endmodule

// [testbench/tb_top.sv]
// register-level testbench for the gps sample capture block
`timescale 1ns/1ps
module tb_top;
  import gps_capture_pkg::*;
  logic mclk = 1'h0, rstn = 1'h0, ce = 1'h1, rxReady = 1'h1;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, rxData;
  logic pready, pslverr, rxValid, spiRxDeny, gpsClk, gpsSign;
  logic [2:0] gpsMag;
  logic [31:0] q[$];
  logic [5:0] cfgs[7] = '{6'h09, 6'h01, 6'h0B, 6'h03, 6'h05, 6'h0D, 6'h0F};
  int errorCnt = 0, nCompared = 0, cyc = 0;

  gps_sample_capture dut (.mclk(mclk), .rstn(rstn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .gpsClk(gpsClk),
    .gpsSign(gpsSign), .gpsMag(gpsMag), .rxData(rxData), .rxValid(rxValid),
    .rxReady(rxReady), .spiRxDeny(spiRxDeny));
  gps_source src (.gpsClk(gpsClk), .gpsSign(gpsSign), .gpsMag(gpsMag));

  always #25 mclk = ~mclk;

  // collect every word the receiver accepts
  always @(posedge mclk) begin
    // one fixed 32-bit access size for the whole run, so no flush is due
    if (rstn && rxValid === 1'h1 && rxReady) q.push_back(rxData);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errorCnt++;
      final_report();
    end
  end

  task final_report;
    $display("errors=%0d compared=%0d", errorCnt, nCompared);
    if (errorCnt == 0 && nCompared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    nCompared++;
    if (g !== e) begin
      errorCnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task waitc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // apb transfer: held until pready is seen high, error flag compared
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           input logic err, output logic [31:0] r);
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    // no local limit: only the bench timeout may end this wait
    @(posedge mclk);
    while (pready !== 1'h1) @(posedge mclk);
    r = prdata;
    chk({31'h0, pslverr}, {31'h0, err});
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'h1, a, d, 1'h0, r);
  endtask

  task rdchk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(1'h0, a, 32'h00000000, 1'h0, r);
    chk(r, e);
  endtask

  // one full word in the given format, expectation built slot by slot
  task fmt_case(input logic [5:0] c);
    logic [31:0] w;
    logic [3:0] s, v;
    int k, n;
    wr(CFG_OFS, {26'h0, c});
    rdchk(CFG_OFS, {26'h0, c});
    k = (c[2:1] == 2'h1 || (c[2:1] == 2'h2 && c[3])) ? 4 :
        (c[2:1] == 2'h2) ? 2 : 0;
    n = (k == 0) ? 1 : 32 / k;
    w = 32'h00000000;
    for (int i = 0; i < n; i++) begin
      s = 4'(i * 5 + 3);
      v = c[3] ? s : {2'h0, s[3], s[0]};
      w |= 32'(v) << (i * k);
      src.send(s, s);
    end
    waitc(12);
    chk(32'(q.size()), 32'h1);
    chk(q.pop_front(), w);
    chk({31'h0, spiRxDeny}, 32'h1);
  endtask

  initial begin
    logic [31:0] r;
    waitc(3);
    rstn <= 1'h1;
    rdchk(CFG_OFS, 32'h00000000);
    rdchk(HANDOVER_OFS, HANDOVER_RESET);
    rdchk(TALLY_OFS, TALLY_RESET);
    apb(1'h0, 12'h034, 32'h00000000, 1'h1, r);
    chk(r, 32'h00000000);
    apb(1'h0, 12'h025, 32'h00000000, 1'h1, r);
    chk(r, 32'h00000000);
    foreach (cfgs[i]) fmt_case(cfgs[i]);
    // flip polarity while disabled so the flip makes no edge
    wr(CFG_OFS, 32'h00000010);
    wr(CFG_OFS, 32'h00000019);
    src.send(4'h3, 4'h5);
    waitc(12);
    chk(q.pop_front(), 32'h00000005);
    wr(CFG_OFS, 32'h00000008);
    src.send(4'h6, 4'h6);
    waitc(12);
    chk(32'(q.size()), 32'h0);
    chk({31'h0, spiRxDeny}, 32'h0);
    // stalled receiver: two words held, third refused
    wr(CFG_OFS, 32'h00000009);
    rxReady <= 1'h0;
    for (int i = 1; i < 4; i++) src.send(4'(i), 4'(i));
    waitc(12);
    chk({31'h0, rxValid}, 32'h1);
    rdchk(STATUS_OFS, 32'h00000001);
    rxReady <= 1'h1;
    waitc(4);
    chk(q.pop_front(), 32'h00000001);
    chk(q.pop_front(), 32'h00000002);
    chk({31'h0, rxValid}, 32'h0);
    wr(STATUS_OFS, 32'h00000001);
    rdchk(STATUS_OFS, 32'h00000000);
    // tracking: countdown of three, chunk-sized handover
    wr(HANDOVER_OFS, 32'h00000003);
    rdchk(HANDOVER_OFS, 32'h00000003);
    wr(CFG_OFS, 32'h00000029);
    repeat (5) src.send(4'h9, 4'h9);
    waitc(12);
    chk(32'(q.size()), 32'h3);
    rdchk(TALLY_OFS, 32'h00000002);
    rdchk(STATUS_OFS, 32'h00000002);
    wr(TALLY_OFS, 32'h00000055);
    rdchk(TALLY_OFS, 32'h00000002);
    wr(CFG_OFS, 32'h00000009);
    src.send(4'h4, 4'h4);
    waitc(12);
    chk(32'(q.size()), 32'h4);
    rdchk(TALLY_OFS, 32'h00000002);
    wr(CFG_OFS, 32'h00000029);
    repeat (3) src.send(4'h7, 4'h7);
    waitc(12);
    chk(32'(q.size()), 32'h6);
    rdchk(TALLY_OFS, 32'h00000001);
    final_report();
  end
endmodule
